// ===== rtl/pfcp_protect.sv
// pfc protection sequencer with gate forcing and axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "pfcp_defs.svh"

module pfcp_protect #(
  parameter int unsigned UV_DELAY_CYCLES = `PFCP_UV_DELAY_CYC,
  parameter int unsigned UV_CNT_W = 19
) (
  input wire logic clk_sys,
  input wire logic nrst,
  // comparator results from the analog front end
  input wire logic cs_below_low,
  input wire logic cs_below_high,
  input wire logic cs_open,
  input wire logic fb_above_soft,
  input wire logic fb_above_hard,
  input wire logic fb_below_old_low,
  input wire logic fb_above_old_high,
  input wire logic fb_above_boost_arm,
  input wire logic fb_below_boost_act,
  input wire logic vin_below_uv,
  input wire logic vin_open,
  input wire logic temp_above_high,
  input wire logic temp_below_low,
  input wire logic supply_ok,
  // pulse requests from the on/off time generator
  input wire logic pulse_req_a,
  input wire logic pulse_req_b,
  // gate and loop-filter controls
  output logic gate_drive_a,
  output logic gate_drive_b,
  output logic comp_sink_en,
  output logic comp_src_small_en,
  output logic comp_src_large_en,
  // axi4-lite slave
  input wire logic [`PFCP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PFCP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic aw_have;
    logic [`PFCP_ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] ctrl;
    logic [7:0] events;
    pfcp_pkg::pfcp_run_t run;
    logic gate_a;
    logic gate_b;
    logic cut_a;
    logic cut_b;
    logic first_a;
    logic ov_soft;
    logic ov_hard;
    logic old_stop;
    logic hot;
    logic boost_armed;
    logic sink;
    logic src_small;
    logic src_large;
  } pfcp_core_t;

  pfcp_core_t c_reg;
  pfcp_core_t c_next;

  pfcp_cmp_if cmp_bus ();
  logic uv_qual;

  // ----------------------------------------
  // comparator synchronisation and delay
  // ----------------------------------------
  assign cmp_bus.raw = {supply_ok, temp_below_low, temp_above_high, vin_open, vin_below_uv,
                        fb_below_boost_act, fb_above_boost_arm, fb_above_old_high,
                        fb_below_old_low, fb_above_hard, fb_above_soft, cs_open,
                        cs_below_high, cs_below_low};

  pfcp_sync u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cmp(cmp_bus.sync)
  );

  pfcp_qual_timer #(
    .DELAY(UV_DELAY_CYCLES),
    .CNT_W(UV_CNT_W)
  ) u_uv_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .level(cmp_bus.synced[`PFCP_C_VIN_UV]),
    .qualified(uv_qual)
  );

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic pfcp_pkg::pfcp_sel_t reg_sel(input logic [`PFCP_ADDR_W-1:0] addr);
    case (addr)
      `PFCP_OFS_CTRL: reg_sel = pfcp_pkg::PFCP_SEL_CTRL;
      `PFCP_OFS_STATUS: reg_sel = pfcp_pkg::PFCP_SEL_STATUS;
      `PFCP_OFS_EVENT: reg_sel = pfcp_pkg::PFCP_SEL_EVENT;
      default: reg_sel = pfcp_pkg::PFCP_SEL_NONE;
    endcase
  endfunction : reg_sel

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic cs_lo;
  logic cs_hi;
  logic cs_op;
  logic fb_soft;
  logic fb_hard;
  logic fb_old_lo;
  logic fb_old_hi;
  logic fb_arm;
  logic fb_act;
  logic vin_op;
  logic t_hi;
  logic t_lo;
  logic sup_ok;
  logic hold_all;
  logic hold_b;
  logic start_ok;
  logic oc_low_cut;
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  logic [31:0] status_word;
  pfcp_pkg::pfcp_sel_t wsel;

  always_comb begin
    c_next = c_reg;
    cs_lo = cmp_bus.synced[`PFCP_C_CS_LOW];
    cs_hi = cmp_bus.synced[`PFCP_C_CS_HIGH];
    cs_op = cmp_bus.synced[`PFCP_C_CS_OPEN];
    fb_soft = cmp_bus.synced[`PFCP_C_FB_SOFT];
    fb_hard = cmp_bus.synced[`PFCP_C_FB_HARD];
    fb_old_lo = cmp_bus.synced[`PFCP_C_FB_OLD_LO];
    fb_old_hi = cmp_bus.synced[`PFCP_C_FB_OLD_HI];
    fb_arm = cmp_bus.synced[`PFCP_C_FB_BOOST_ARM];
    fb_act = cmp_bus.synced[`PFCP_C_FB_BOOST_ACT];
    vin_op = cmp_bus.synced[`PFCP_C_VIN_OPEN];
    t_hi = cmp_bus.synced[`PFCP_C_TEMP_HI];
    t_lo = cmp_bus.synced[`PFCP_C_TEMP_LO];
    sup_ok = cmp_bus.synced[`PFCP_C_SUPPLY_OK];
    ev_set = '0;
    ev_clr = '0;

    // overvoltage with hysteresis; open feedback pin rises into it
    if (fb_soft) begin
      c_next.ov_soft = 1'b1;
    end
    if (fb_hard) begin
      c_next.ov_hard = 1'b1;
    end
    if (!fb_soft) begin
      c_next.ov_soft = 1'b0;
      c_next.ov_hard = 1'b0;
    end

    // open loop with hysteresis
    if (fb_old_lo) begin
      c_next.old_stop = 1'b1;
    end else if (fb_old_hi) begin
      c_next.old_stop = 1'b0;
    end

    // thermal with hysteresis
    if (t_hi) begin
      c_next.hot = 1'b1;
    end else if (t_lo) begin
      c_next.hot = 1'b0;
    end

    // run sequencing
    start_ok = sup_ok && !c_next.old_stop && c_reg.ctrl[`PFCP_CTRL_EN_BIT];
    unique case (c_reg.run)
      pfcp_pkg::PFCP_STANDBY: begin
        if (start_ok) begin
          c_next.run = pfcp_pkg::PFCP_SOFT;
        end
      end
      pfcp_pkg::PFCP_SOFT: begin
        if (!start_ok) begin
          c_next.run = pfcp_pkg::PFCP_STANDBY;
        end else if (!uv_qual && !fb_act) begin
          c_next.run = pfcp_pkg::PFCP_RUN;
        end
      end
      pfcp_pkg::PFCP_RUN: begin
        if (!start_ok) begin
          c_next.run = pfcp_pkg::PFCP_STANDBY;
        end else if (uv_qual) begin
          c_next.run = pfcp_pkg::PFCP_SOFT;
        end
      end
      default: begin
        c_next.run = pfcp_pkg::PFCP_STANDBY;
      end
    endcase

    // fast response boost
    if (uv_qual || c_next.run != pfcp_pkg::PFCP_RUN) begin
      c_next.boost_armed = 1'b0;
    end else if (fb_arm) begin
      c_next.boost_armed = 1'b1;
    end

    // loop-filter node sources and sink
    c_next.sink = c_next.ov_soft || uv_qual;
    c_next.src_small = (c_next.run == pfcp_pkg::PFCP_SOFT) && !c_next.sink;
    c_next.src_large = c_next.boost_armed && fb_act && !c_next.sink;

    // gate forcing
    hold_all = !sup_ok || !c_reg.ctrl[`PFCP_CTRL_EN_BIT] || c_next.run == pfcp_pkg::PFCP_STANDBY
               || c_next.ov_hard || c_next.old_stop || c_next.hot || cs_op
               || (vin_op && !c_reg.ctrl[`PFCP_CTRL_LIMIT_BIT]);
    hold_b = vin_op && c_reg.ctrl[`PFCP_CTRL_LIMIT_BIT];

    // pulse-by-pulse cuts end when the request drops
    if (!pulse_req_a) begin
      c_next.cut_a = 1'b0;
    end
    if (!pulse_req_b) begin
      c_next.cut_b = 1'b0;
    end
    oc_low_cut = 1'b0;
    if (cs_hi) begin
      c_next.cut_a = c_reg.gate_a || c_next.cut_a;
      c_next.cut_b = c_reg.gate_b || c_next.cut_b;
      ev_set[1] = c_reg.gate_a || c_reg.gate_b;
    end else if (cs_lo) begin
      oc_low_cut = c_reg.gate_a || c_reg.gate_b;
      if (c_reg.gate_a && c_reg.gate_b) begin
        if (c_reg.first_a) begin
          c_next.cut_a = 1'b1;
        end else begin
          c_next.cut_b = 1'b1;
        end
      end else if (c_reg.gate_a) begin
        c_next.cut_a = 1'b1;
      end else if (c_reg.gate_b) begin
        c_next.cut_b = 1'b1;
      end
    end
    c_next.gate_a = pulse_req_a && !c_next.cut_a && !hold_all;
    c_next.gate_b = pulse_req_b && !c_next.cut_b && !hold_all && !hold_b;
    if (c_next.gate_a && !c_next.gate_b) begin
      c_next.first_a = 1'b1;
    end else if (c_next.gate_b && !c_next.gate_a) begin
      c_next.first_a = 1'b0;
    end

    // event flags
    ev_set[0] = oc_low_cut;
    ev_set[2] = c_next.ov_hard && !c_reg.ov_hard;
    ev_set[3] = c_next.old_stop && !c_reg.old_stop;
    ev_set[4] = uv_qual && !c_reg.sink;
    ev_set[5] = c_next.hot && !c_reg.hot;
    ev_set[6] = cs_op || vin_op;
    ev_set[7] = c_next.ov_soft && !c_reg.ov_soft;

    // axi write channel
    if (s_axi_awvalid && c_reg.awready) begin
      c_next.aw_have = 1'b1;
      c_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && c_reg.wready) begin
      c_next.w_have = 1'b1;
      c_next.w_data = s_axi_wdata;
      c_next.w_strb = s_axi_wstrb;
    end
    if (c_reg.bvalid && s_axi_bready) begin
      c_next.bvalid = 1'b0;
    end
    wsel = reg_sel(c_reg.aw_addr);
    if (c_reg.aw_have && c_reg.w_have && !c_reg.bvalid) begin
      c_next.aw_have = 1'b0;
      c_next.w_have = 1'b0;
      c_next.bvalid = 1'b1;
      c_next.bresp = `PFCP_RESP_OKAY;
      unique case (wsel)
        pfcp_pkg::PFCP_SEL_CTRL: begin
          if (c_reg.w_strb[0]) begin
            c_next.ctrl = c_reg.w_data[1:0];
          end
        end
        pfcp_pkg::PFCP_SEL_EVENT: begin
          if (c_reg.w_strb[0]) begin
            ev_clr = c_reg.w_data[7:0];
          end
        end
        pfcp_pkg::PFCP_SEL_STATUS: begin
          c_next.bresp = `PFCP_RESP_OKAY;
        end
        pfcp_pkg::PFCP_SEL_NONE: begin
          c_next.bresp = `PFCP_RESP_SLVERR;
        end
      endcase
    end
    // set wins over a same-cycle clear
    c_next.events = (c_reg.events & ~ev_clr) | ev_set;

    // axi read channel
    status_word = {19'h00000, c_reg.run, vin_op, cs_op, c_reg.src_large, c_reg.boost_armed,
                   uv_qual, c_reg.hot, c_reg.old_stop, c_reg.ov_hard, c_reg.ov_soft,
                   c_reg.gate_b, c_reg.gate_a};
    if (c_reg.rvalid && s_axi_rready) begin
      c_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && c_reg.arready) begin
      c_next.rvalid = 1'b1;
      c_next.rresp = `PFCP_RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        pfcp_pkg::PFCP_SEL_CTRL: c_next.rdata = {30'h00000000, c_reg.ctrl};
        pfcp_pkg::PFCP_SEL_STATUS: c_next.rdata = status_word;
        pfcp_pkg::PFCP_SEL_EVENT: c_next.rdata = {24'h000000, c_reg.events};
        pfcp_pkg::PFCP_SEL_NONE: begin
          c_next.rdata = 32'h00000000;
          c_next.rresp = `PFCP_RESP_SLVERR;
        end
      endcase
    end
    c_next.awready = !c_next.aw_have && !c_next.bvalid;
    c_next.wready = !c_next.w_have && !c_next.bvalid;
    c_next.arready = !c_next.rvalid;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      c_reg <= '0;
      c_reg.ctrl <= `PFCP_CTRL_RST;
      c_reg.run <= pfcp_pkg::PFCP_STANDBY;
      c_reg.old_stop <= 1'b1;
      c_reg.first_a <= 1'b1;
    end else begin
      c_reg <= c_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign gate_drive_a = c_reg.gate_a;
  assign gate_drive_b = c_reg.gate_b;
  assign comp_sink_en = c_reg.sink;
  assign comp_src_small_en = c_reg.src_small;
  assign comp_src_large_en = c_reg.src_large;
  assign s_axi_awready = c_reg.awready;
  assign s_axi_wready = c_reg.wready;
  assign s_axi_bvalid = c_reg.bvalid;
  assign s_axi_bresp = c_reg.bresp;
  assign s_axi_arready = c_reg.arready;
  assign s_axi_rvalid = c_reg.rvalid;
  assign s_axi_rdata = c_reg.rdata;
  assign s_axi_rresp = c_reg.rresp;

endmodule : pfcp_protect

`default_nettype wire

// ===== rtl/pfcp_defs.svh
// constants, offsets and field positions of the pfc protection block
// Notes on behaviour
// - one combined current sense for all overcurrent
// - low current threshold ends present gate pulse
// - single high output: only that one cut
// - both high: cut the earlier-started output
// - high current threshold cuts every output that is high, per pulse
// - soft overvoltage sinks loop-filter node current
// - hard overvoltage holds both gates low
// - both overvoltage states clear below soft level
// - open-loop low level stops all switching
// - open-loop restart only above high level
// - open feedback pin acts as overvoltage
// - open current pin holds both gates low
// - open input pin limits or stops switching
// - qualified input undervoltage discharges node, disables boost
// - undervoltage release restarts through soft-start
// - over-temperature stops switching on both gates
// - thermal restart only below lower threshold
// - soft-start charges node with small source
// - fast boost armed high, acts when low
`ifndef PFCP_DEFS_SVH
`define PFCP_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PFCP_CLK_HZ 20000000
`define PFCP_UV_DELAY_MS 14
`define PFCP_UV_DELAY_CYC (`PFCP_UV_DELAY_MS * (`PFCP_CLK_HZ / 1000))

// ----------------------------------------
// comparator vector positions
// ----------------------------------------
`define PFCP_NCMP 14
`define PFCP_C_CS_LOW 0
`define PFCP_C_CS_HIGH 1
`define PFCP_C_CS_OPEN 2
`define PFCP_C_FB_SOFT 3
`define PFCP_C_FB_HARD 4
`define PFCP_C_FB_OLD_LO 5
`define PFCP_C_FB_OLD_HI 6
`define PFCP_C_FB_BOOST_ARM 7
`define PFCP_C_FB_BOOST_ACT 8
`define PFCP_C_VIN_UV 9
`define PFCP_C_VIN_OPEN 10
`define PFCP_C_TEMP_HI 11
`define PFCP_C_TEMP_LO 12
`define PFCP_C_SUPPLY_OK 13

// ----------------------------------------
// register map
// ----------------------------------------
`define PFCP_ADDR_W 4
`define PFCP_OFS_CTRL 4'h0
`define PFCP_OFS_STATUS 4'h4
`define PFCP_OFS_EVENT 4'h8
`define PFCP_CTRL_RST 2'h1
`define PFCP_CTRL_EN_BIT 0
`define PFCP_CTRL_LIMIT_BIT 1
`define PFCP_RESP_OKAY 2'h0
`define PFCP_RESP_SLVERR 2'h2

`endif

// ===== rtl/pfcp_pkg.sv
// types shared by the pfc protection block
package pfcp_pkg;

  typedef enum logic [1:0] {
    PFCP_STANDBY = 2'b00,
    PFCP_SOFT = 2'b01,
    PFCP_RUN = 2'b10
  } pfcp_run_t;

  typedef enum logic [1:0] {
    PFCP_SEL_CTRL = 2'b00,
    PFCP_SEL_STATUS = 2'b01,
    PFCP_SEL_EVENT = 2'b10,
    PFCP_SEL_NONE = 2'b11
  } pfcp_sel_t;

endpackage : pfcp_pkg

// ===== rtl/pfcp_cmp_if.sv
// carrier for the comparator flags between sync stage and core
`timescale 1ns/1ps
`default_nettype none
`include "pfcp_defs.svh"

interface pfcp_cmp_if;
  logic [`PFCP_NCMP-1:0] raw;
  logic [`PFCP_NCMP-1:0] synced;
  modport core (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : pfcp_cmp_if

`default_nettype wire

// ===== rtl/pfcp_sync.sv
// two-flop synchroniser bank for the comparator flags
`timescale 1ns/1ps
`default_nettype none
`include "pfcp_defs.svh"

module pfcp_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  pfcp_cmp_if.sync cmp
);
  typedef struct packed {
    logic [`PFCP_NCMP-1:0] meta;
    logic [`PFCP_NCMP-1:0] stable;
  } pfcp_sync_t;

  pfcp_sync_t s_reg;
  pfcp_sync_t s_next;

  always_comb begin
    s_next.meta = cmp.raw;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmp.synced = s_reg.stable;
endmodule : pfcp_sync

`default_nettype wire

// ===== rtl/pfcp_qual_timer.sv
// qualification delay: output rises after level held for DELAY cycles
`timescale 1ns/1ps
`default_nettype none

module pfcp_qual_timer #(
  parameter int unsigned DELAY = 280000,
  parameter int unsigned CNT_W = 19
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic level,
  output logic qualified
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic qual;
  } pfcp_qual_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY - 1);

  pfcp_qual_t t_reg;
  pfcp_qual_t t_next;

  always_comb begin
    t_next = t_reg;
    if (!level) begin
      t_next.cnt = '0;
      t_next.qual = 1'b0;
    end else if (t_reg.cnt == LAST) begin
      t_next.qual = 1'b1;
    end else begin
      t_next.cnt = t_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign qualified = t_reg.qual;
endmodule : pfcp_qual_timer

`default_nettype wire

// ===== bench/pfcp_sense_model.sv
// sense network model: pin levels in mV and deg C to comparator flags
`timescale 1ns/1ps
`default_nettype none

module pfcp_sense_model (
  input var int cs_mv,
  input var int fb_mv,
  input var int in_mv,
  input var int temp_c,
  input wire logic cs_open_pin,
  input wire logic fb_open_pin,
  input wire logic in_open_pin,
  output logic cs_below_low,
  output logic cs_below_high,
  output logic cs_open,
  output logic fb_above_soft,
  output logic fb_above_hard,
  output logic fb_below_old_low,
  output logic fb_above_old_high,
  output logic fb_above_boost_arm,
  output logic fb_below_boost_act,
  output logic vin_below_uv,
  output logic vin_open,
  output logic temp_above_high,
  output logic temp_below_low
);
  // ----
  // comparators, open pins pulled up
  // ----
  assign cs_below_low = !cs_open_pin && cs_mv <= -420;
  assign cs_below_high = !cs_open_pin && cs_mv <= -550;
  assign cs_open = cs_open_pin;
  assign fb_above_soft = fb_open_pin || fb_mv >= 3680;
  assign fb_above_hard = fb_open_pin || fb_mv >= 3720;
  assign fb_below_old_low = !fb_open_pin && fb_mv <= 500;
  assign fb_above_old_high = fb_open_pin || fb_mv >= 700;
  assign fb_above_boost_arm = fb_open_pin || fb_mv >= 3400;
  assign fb_below_boost_act = !fb_open_pin && fb_mv <= 3200;
  assign vin_below_uv = !in_open_pin && in_mv <= 300;
  assign vin_open = in_open_pin;
  assign temp_above_high = temp_c >= 150;
  assign temp_below_low = temp_c <= 140;
endmodule : pfcp_sense_model

`default_nettype wire

// ===== bench/pfcp_protect_assertions.sv
// concurrent checks on the pfc protection block ports
`timescale 1ns/1ps
`default_nettype none

module pfcp_protect_assertions #(
  parameter int unsigned UV_DELAY_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cs_below_high,
  input wire logic cs_open,
  input wire logic fb_above_soft,
  input wire logic fb_above_hard,
  input wire logic fb_below_old_low,
  input wire logic vin_below_uv,
  input wire logic temp_above_high,
  input wire logic pulse_req_a,
  input wire logic pulse_req_b,
  input wire logic gate_drive_a,
  input wire logic gate_drive_b,
  input wire logic comp_sink_en,
  input wire logic comp_src_small_en,
  input wire logic comp_src_large_en,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----
  // helper: run length of low input
  // ----
  int uv_cnt;
  always_ff @(posedge clk_sys) begin
    uv_cnt <= (!nrst || !vin_below_uv) ? 0 : uv_cnt + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----
  // properties
  // ----
  hard_cut_a: assert property (cs_below_high |-> ##3 !gate_drive_a && !gate_drive_b)
    else $error("gates not cut on high current");
  over_volt_a: assert property (fb_above_hard |-> ##3 !gate_drive_a && !gate_drive_b)
    else $error("gates not held on overvoltage");
  pin_open_a: assert property (cs_open |-> ##3 !gate_drive_a && !gate_drive_b)
    else $error("gates not held on open current pin");
  loop_stop_a: assert property (fb_below_old_low |-> ##3 !gate_drive_a && !gate_drive_b)
    else $error("gates not stopped on open loop");
  heat_stop_a: assert property (temp_above_high |-> ##3 !gate_drive_a && !gate_drive_b)
    else $error("gates not stopped on heat");
  soft_sink_a: assert property (fb_above_soft |-> ##3 comp_sink_en)
    else $error("sink not on at soft overvoltage");
  sink_only_a: assert property (comp_sink_en |-> !comp_src_small_en && !comp_src_large_en)
    else $error("source on with sink");
  uv_qual_a: assert property (uv_cnt == UV_DELAY_CYCLES + 8 |-> comp_sink_en && !comp_src_large_en)
    else $error("no discharge after qualified undervoltage");
  req_a_a: assert property (!pulse_req_a |=> !gate_drive_a)
    else $error("gate a high without request");
  req_b_a: assert property (!pulse_req_b |=> !gate_drive_b)
    else $error("gate b high without request");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
endmodule : pfcp_protect_assertions

`default_nettype wire

// ===== bench/pfcp_protect_test.sv
// self-checking bench for the pfc protection block
`timescale 1ns/1ps
`default_nettype none
`include "pfcp_defs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end

module pfcp_protect_test;
  // ----
  // signals
  // ----
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic supply_ok = 1'h1;
  logic pulse_req_a = 1'h0;
  logic pulse_req_b = 1'h0;
  logic cs_open_pin = 1'h0;
  logic fb_open_pin = 1'h0;
  logic in_open_pin = 1'h0;
  int cs_mv = 0;
  int fb_mv = 2000;
  int in_mv = 1000;
  int temp_c = 25;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] rv;
  logic cs_below_low, cs_below_high, cs_open, fb_above_soft, fb_above_hard, fb_below_old_low;
  logic fb_above_old_high, fb_above_boost_arm, fb_below_boost_act, vin_below_uv, vin_open;
  logic temp_above_high, temp_below_low, gate_drive_a, gate_drive_b;
  logic comp_sink_en, comp_src_small_en, comp_src_large_en;
  logic [`PFCP_ADDR_W-1:0] s_axi_awaddr = 4'h0;
  logic [`PFCP_ADDR_W-1:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;

  always #25 clk_sys = ~clk_sys;

  pfcp_protect #(.UV_DELAY_CYCLES(20), .UV_CNT_W(5)) pfcp_protect_i (.clk_sys, .nrst, .cs_below_low,
    .cs_below_high, .cs_open, .fb_above_soft, .fb_above_hard, .fb_below_old_low, .fb_above_old_high,
    .fb_above_boost_arm, .fb_below_boost_act, .vin_below_uv, .vin_open, .temp_above_high, .temp_below_low,
    .supply_ok, .pulse_req_a, .pulse_req_b, .gate_drive_a, .gate_drive_b, .comp_sink_en, .comp_src_small_en,
    .comp_src_large_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  pfcp_sense_model pfcp_sense_model_i (.cs_mv, .fb_mv, .in_mv, .temp_c, .cs_open_pin, .fb_open_pin,
    .in_open_pin, .cs_below_low, .cs_below_high, .cs_open, .fb_above_soft, .fb_above_hard,
    .fb_below_old_low, .fb_above_old_high, .fb_above_boost_arm, .fb_below_boost_act, .vin_below_uv,
    .vin_open, .temp_above_high, .temp_below_low);

  // ----
  // shared tasks
  // ----
  task automatic wrap_up;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : w
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    `CHK(s_axi_bresp, r)
    w(1);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [1:0] r, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
    `CHK(s_axi_rresp, r)
    w(1);
  endtask : rd
  task automatic gt(input logic ea, input logic eb);
    `CHK(gate_drive_a, ea)
    `CHK(gate_drive_b, eb)
  endtask : gt
  task automatic rr;
    pulse_req_a <= 1'h0;
    pulse_req_b <= 1'h0;
    w(2);
    pulse_req_a <= 1'h1;
    pulse_req_b <= 1'h1;
    w(2);
  endtask : rr

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rd(`PFCP_OFS_CTRL, `PFCP_RESP_OKAY, rv);
    `CHK(rv, 32'h1)
    rd(4'hC, `PFCP_RESP_SLVERR, rv);
    `CHK(rv, 32'h0)
    wr(4'hC, 32'h0, `PFCP_RESP_SLVERR);
    wr(`PFCP_OFS_STATUS, 32'h0, `PFCP_RESP_OKAY);
  endtask : t_regs
  task automatic t_start;
    `CHK(comp_src_small_en, 1'h1)
    fb_mv <= 3500;
    w(4);
    rr();
    gt(1'h1, 1'h1);
    fb_mv <= 3100;
    w(4);
    `CHK(comp_src_large_en, 1'h1)
    fb_mv <= 3300;
    w(4);
  endtask : t_start
  task automatic t_cut_low;
    pulse_req_a <= 1'h0;
    pulse_req_b <= 1'h0;
    w(2);
    pulse_req_a <= 1'h1;
    w(1);
    pulse_req_b <= 1'h1;
    w(2);
    cs_mv <= -450;
    w(1);
    cs_mv <= 0;
    w(3);
    gt(1'h0, 1'h1);
    rd(`PFCP_OFS_EVENT, `PFCP_RESP_OKAY, rv);
    `CHK(rv[0], 1'h1)
    wr(`PFCP_OFS_EVENT, 32'h1, `PFCP_RESP_OKAY);
    rd(`PFCP_OFS_EVENT, `PFCP_RESP_OKAY, rv);
    `CHK(rv[0], 1'h0)
    pulse_req_a <= 1'h0;
    pulse_req_b <= 1'h0;
    w(2);
    pulse_req_a <= 1'h1;
    w(2);
    cs_mv <= -450;
    w(1);
    cs_mv <= 0;
    w(3);
    pulse_req_b <= 1'h1;
    w(2);
    gt(1'h0, 1'h1);
  endtask : t_cut_low
  task automatic t_cut_high;
    rr();
    cs_mv <= -600;
    w(1);
    cs_mv <= 0;
    w(3);
    gt(1'h0, 1'h0);
    rr();
    gt(1'h1, 1'h1);
  endtask : t_cut_high
  task automatic t_overvolt;
    fb_mv <= 3690;
    w(4);
    `CHK(comp_sink_en, 1'h1)
    fb_mv <= 3730;
    w(4);
    gt(1'h0, 1'h0);
    fb_mv <= 3700;
    w(4);
    rr();
    gt(1'h0, 1'h0);
    fb_mv <= 3300;
    w(4);
    rr();
    gt(1'h1, 1'h1);
    fb_open_pin <= 1'h1;
    w(4);
    gt(1'h0, 1'h0);
    fb_open_pin <= 1'h0;
    w(4);
  endtask : t_overvolt
  task automatic t_loop;
    fb_mv <= 400;
    w(4);
    gt(1'h0, 1'h0);
    fb_mv <= 600;
    w(4);
    rr();
    gt(1'h0, 1'h0);
    fb_mv <= 800;
    w(4);
    rr();
    gt(1'h1, 1'h1);
    fb_mv <= 3300;
    w(4);
  endtask : t_loop
  task automatic t_pins;
    cs_open_pin <= 1'h1;
    w(4);
    gt(1'h0, 1'h0);
    cs_open_pin <= 1'h0;
    in_open_pin <= 1'h1;
    w(4);
    rr();
    gt(1'h0, 1'h0);
    wr(`PFCP_OFS_CTRL, 32'h3, `PFCP_RESP_OKAY);
    rr();
    gt(1'h1, 1'h0);
    in_open_pin <= 1'h0;
    wr(`PFCP_OFS_CTRL, 32'h1, `PFCP_RESP_OKAY);
  endtask : t_pins
  task automatic t_under;
    fb_mv <= 3500;
    w(4);
    fb_mv <= 3000;
    in_mv <= 200;
    w(10);
    `CHK(comp_sink_en, 1'h0)
    `CHK(comp_src_large_en, 1'h1)
    w(20);
    `CHK(comp_sink_en, 1'h1)
    `CHK(comp_src_large_en, 1'h0)
    in_mv <= 1000;
    w(5);
    `CHK(comp_src_small_en, 1'h1)
    fb_mv <= 3300;
    w(4);
  endtask : t_under
  task automatic t_heat;
    temp_c <= 155;
    w(4);
    gt(1'h0, 1'h0);
    temp_c <= 145;
    w(4);
    rr();
    gt(1'h0, 1'h0);
    temp_c <= 135;
    w(4);
    rr();
    gt(1'h1, 1'h1);
  endtask : t_heat

  // ----
  // sequence and timeout
  // ----
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    w(5);
    nrst <= 1'h1;
    w(4);
    t_regs();
    t_start();
    t_cut_low();
    t_cut_high();
    t_overvolt();
    t_loop();
    t_pins();
    t_under();
    t_heat();
    wrap_up();
  end
endmodule : pfcp_protect_test

bind pfcp_protect pfcp_protect_assertions #(.UV_DELAY_CYCLES(UV_DELAY_CYCLES)) pfcp_protect_assertions_i (
  .clk_sys, .nrst, .cs_below_high, .cs_open, .fb_above_soft, .fb_above_hard, .fb_below_old_low,
  .vin_below_uv, .temp_above_high, .pulse_req_a, .pulse_req_b, .gate_drive_a, .gate_drive_b, .comp_sink_en,
  .comp_src_small_en, .comp_src_large_en, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

`default_nettype wire
